// *** icu_pkg.sv ***
package icu_pkg;

    // Capture mode codes held in the low nibble of the control register.
    localparam logic [3:0] MODE_OFF     = 4'h0;
    localparam logic [3:0] MODE_FALL    = 4'h4;
    localparam logic [3:0] MODE_RISE    = 4'h5;
    localparam logic [3:0] MODE_RISE4   = 4'h6;
    localparam logic [3:0] MODE_RISE16  = 4'h7;

    // Register indexes on the plain register port.
    localparam logic [2:0] ADDR_CTRL    = 3'h0;
    localparam logic [2:0] ADDR_CAP_LO  = 3'h1;
    localparam logic [2:0] ADDR_CAP_HI  = 3'h2;
    localparam logic [2:0] ADDR_FLAGS   = 3'h3;
    localparam logic [2:0] ADDR_ENABLES = 3'h4;
    localparam logic [2:0] ADDR_T3CTRL  = 3'h5;
    localparam logic [2:0] ADDR_DIR     = 3'h6;
    localparam logic [2:0] ADDR_PORT    = 3'h7;

    // Field positions.
    localparam int FLAG_BIT             = 2;
    localparam int DIR_BIT              = 2;
    localparam int TSEL_BIT             = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] DIR_RST      = 8'hFF;
    localparam logic [7:0] T3CTRL_RST   = 8'h00;

    // Prescaler terminal counts (events minus one).
    localparam logic [3:0] PRE4_LAST    = 4'h3;
    localparam logic [3:0] PRE16_LAST   = 4'hF;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } icu_bus_req_t;

    typedef enum logic [1:0] {
        ICU_OFF     = 2'b00,
        ICU_CAPTURE = 2'b01,
        ICU_OTHER   = 2'b10
    } icu_state_t;

endpackage

// *** icu_top.sv ***
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module icu_top (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire icu_pkg::icu_bus_req_t bus_req,
    output logic [7:0]                 rdata,
    input  wire logic                  pin_in,
    output logic                       pin_out,
    output logic                       pin_oe_n,
    input  wire logic [15:0]           first_timer_count,
    input  wire logic [15:0]           third_timer_count,
    output logic                       irq,
    output logic                       capture_pulse
);

    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  t3ctrl_q, t3ctrl_d;
    logic [7:0]  dir_q, dir_d;
    logic [7:0]  port_q, port_d;
    logic        flag_q, flag_d;
    logic        enable_q, enable_d;
    logic [15:0] cap_q, cap_d;
    logic [3:0]  pre_q, pre_d;
    logic        s1_q, s2_q, s3_q;
    logic        s1_d, s2_d, s3_d;
    logic [7:0]  rdata_d;
    logic        irq_d;
    logic        cap_evt;
    logic        pulse_d;
    logic        pin_out_d;
    logic        pin_oe_n_d;
    logic        mode_wr;
    icu_pkg::icu_state_t state;

    function automatic icu_pkg::icu_state_t mode_class(input logic [3:0] m);
        case (m)
            icu_pkg::MODE_OFF:    mode_class = icu_pkg::ICU_OFF;
            icu_pkg::MODE_FALL,
            icu_pkg::MODE_RISE,
            icu_pkg::MODE_RISE4,
            icu_pkg::MODE_RISE16: mode_class = icu_pkg::ICU_CAPTURE;
            default:              mode_class = icu_pkg::ICU_OTHER;
        endcase
    endfunction

    function automatic logic is_wr(input icu_pkg::icu_bus_req_t r, input logic [2:0] a);
        is_wr = r.wr && (r.addr == a);
    endfunction

    assign state   = mode_class(ctrl_q[3:0]);
    assign mode_wr = is_wr(bus_req, icu_pkg::ADDR_CTRL);

    // The pad is read back whatever the direction, so own writes can trigger.
    always_comb begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // Event detection and prescaling on the synchronised pin.
    always_comb begin
        logic rise;
        logic fall;
        rise    = s2_q && !s3_q;
        fall    = !s2_q && s3_q;
        cap_evt = 1'b0;
        pre_d   = pre_q;
        if (state != icu_pkg::ICU_CAPTURE) begin
            pre_d = 4'h0;
        end else begin
            // A direct switch between prescaler modes keeps the count.
            case (ctrl_q[3:0])
                icu_pkg::MODE_FALL:  cap_evt = fall;
                icu_pkg::MODE_RISE:  cap_evt = rise;
                icu_pkg::MODE_RISE4: begin
                    if (rise) begin
                        cap_evt = (pre_q[1:0] == icu_pkg::PRE4_LAST[1:0]);
                        pre_d   = cap_evt ? 4'h0 : pre_q + 4'h1;
                    end
                end
                icu_pkg::MODE_RISE16: begin
                    if (rise) begin
                        cap_evt = (pre_q == icu_pkg::PRE16_LAST);
                        pre_d   = pre_q + 4'h1;
                    end
                end
                default: cap_evt = 1'b0;
            endcase
        end
    end

    // Register file, capture and flag next values.
    always_comb begin
        ctrl_d   = ctrl_q;
        t3ctrl_d = t3ctrl_q;
        dir_d    = dir_q;
        port_d   = port_q;
        enable_d = enable_q;
        flag_d   = flag_q;
        cap_d    = cap_q;
        if (mode_wr) begin
            ctrl_d = bus_req.wdata;
        end
        if (is_wr(bus_req, icu_pkg::ADDR_T3CTRL)) begin
            t3ctrl_d = bus_req.wdata;
        end
        if (is_wr(bus_req, icu_pkg::ADDR_DIR)) begin
            dir_d = bus_req.wdata;
        end
        if (is_wr(bus_req, icu_pkg::ADDR_PORT)) begin
            port_d = bus_req.wdata;
        end
        if (is_wr(bus_req, icu_pkg::ADDR_ENABLES)) begin
            enable_d = bus_req.wdata[icu_pkg::FLAG_BIT];
        end
        if (is_wr(bus_req, icu_pkg::ADDR_FLAGS)) begin
            flag_d = bus_req.wdata[icu_pkg::FLAG_BIT];
        end
        if (cap_evt) begin
            // Source selection is live; software keeps timers synchronous.
            cap_d  = t3ctrl_q[icu_pkg::TSEL_BIT] ? third_timer_count
                                                : first_timer_count;
            flag_d = 1'b1;
        end
        // A mode write while capturing may flag spuriously; here it does so
        // whenever the mode code changes while the synchronised pin is high.
        if (mode_wr && state == icu_pkg::ICU_CAPTURE && s2_q
            && bus_req.wdata[3:0] != ctrl_q[3:0]) begin
            flag_d = 1'b1;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                icu_pkg::ADDR_CTRL:    rdata_d = ctrl_q;
                icu_pkg::ADDR_CAP_LO:  rdata_d = cap_q[7:0];
                icu_pkg::ADDR_CAP_HI:  rdata_d = cap_q[15:8];
                icu_pkg::ADDR_FLAGS:   rdata_d = {5'h00, flag_q, 2'h0};
                icu_pkg::ADDR_ENABLES: rdata_d = {5'h00, enable_q, 2'h0};
                icu_pkg::ADDR_T3CTRL:  rdata_d = t3ctrl_q;
                icu_pkg::ADDR_DIR:     rdata_d = dir_q;
                default:               rdata_d = port_q;
            endcase
        end
        irq_d      = flag_d && enable_d;
        pulse_d    = cap_evt;
        pin_out_d  = port_d[icu_pkg::DIR_BIT];
        pin_oe_n_d = dir_d[icu_pkg::DIR_BIT];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q        <= icu_pkg::CTRL_RST;
            t3ctrl_q      <= icu_pkg::T3CTRL_RST;
            dir_q         <= icu_pkg::DIR_RST;
            port_q        <= 8'h00;
            enable_q      <= 1'b0;
            flag_q        <= 1'b0;
            cap_q         <= 16'h0000;
            pre_q         <= 4'h0;
            rdata         <= 8'h00;
            irq           <= 1'b0;
            capture_pulse <= 1'b0;
            pin_out       <= 1'b0;
            pin_oe_n      <= 1'b1;
        end else begin
            ctrl_q        <= ctrl_d;
            t3ctrl_q      <= t3ctrl_d;
            dir_q         <= dir_d;
            port_q        <= port_d;
            enable_q      <= enable_d;
            flag_q        <= flag_d;
            cap_q         <= cap_d;
            pre_q         <= pre_d;
            rdata         <= rdata_d;
            irq           <= irq_d;
            capture_pulse <= pulse_d;
            pin_out       <= pin_out_d;
            pin_oe_n      <= pin_oe_n_d;
        end
    end

    sequence s_rise;
        !s3_q && s2_q;
    endsequence

    property p_rise_capture;
        @(posedge clk) disable iff (rst)
        (ctrl_q[3:0] == icu_pkg::MODE_RISE && !mode_wr) ##0 s_rise
            |=> capture_pulse && flag_q;
    endproperty
    a_rise_capture: assert property (p_rise_capture) else $error("rise missed");

    property p_fall_capture;
        @(posedge clk) disable iff (rst)
        (ctrl_q[3:0] == icu_pkg::MODE_FALL && s3_q && !s2_q) |=> capture_pulse;
    endproperty
    a_fall_capture: assert property (p_fall_capture) else $error("fall missed");

    property p_value;
        @(posedge clk) disable iff (rst)
        cap_evt |=> cap_q == ($past(t3ctrl_q[icu_pkg::TSEL_BIT]) ? $past(third_timer_count)
                                                                 : $past(first_timer_count));
    endproperty
    a_value: assert property (p_value) else $error("capture value wrong");

    property p_flag_sticky;
        @(posedge clk) disable iff (rst)
        (flag_q && !is_wr(bus_req, icu_pkg::ADDR_FLAGS)) |=> flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_set_wins;
        @(posedge clk) disable iff (rst)
        cap_evt |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("capture did not set flag");

    property p_pre_off;
        @(posedge clk) disable iff (rst)
        (state != icu_pkg::ICU_CAPTURE) |=> pre_q == 4'h0;
    endproperty
    a_pre_off: assert property (p_pre_off) else $error("prescaler not cleared");

    property p_no_spurious;
        @(posedge clk) disable iff (rst)
        (state == icu_pkg::ICU_OFF && !mode_wr) |=> !capture_pulse;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("capture while off");

    property p_irq;
        @(posedge clk) disable iff (rst)
        ##1 (irq == (flag_q && enable_q));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_sync;
        @(posedge clk) disable iff (rst)
        ##2 (s2_q == $past(pin_in, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("sync chain broken");

    // Only a capture, a mode write or a flag write may raise the flag.
    property p_flag_cause;
        @(posedge clk) disable iff (rst)
        (!flag_q && !cap_evt && !mode_wr
            && !is_wr(bus_req, icu_pkg::ADDR_FLAGS)) |=> !flag_q;
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("stray flag");

    property p_pre4_capture;
        @(posedge clk) disable iff (rst)
        (ctrl_q[3:0] == icu_pkg::MODE_RISE4
            && pre_q[1:0] == icu_pkg::PRE4_LAST[1:0]) ##0 s_rise
            |=> capture_pulse && pre_q == 4'h0;
    endproperty
    a_pre4_capture: assert property (p_pre4_capture) else $error("4th rise missed");

    property p_pre_keep;
        @(posedge clk) disable iff (rst)
        (state == icu_pkg::ICU_CAPTURE && !(s2_q && !s3_q)) |=> pre_q == $past(pre_q);
    endproperty
    a_pre_keep: assert property (p_pre_keep) else $error("prescaler moved");

    property p_fall_only;
        @(posedge clk) disable iff (rst)
        (ctrl_q[3:0] == icu_pkg::MODE_FALL && !(s3_q && !s2_q)) |=> !capture_pulse;
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("capture without fall");

    property p_pulse_flag;
        @(posedge clk) disable iff (rst)
        capture_pulse |-> flag_q;
    endproperty
    a_pulse_flag: assert property (p_pulse_flag) else $error("pulse without flag");

endmodule // icu_top

// *** icu_far_model.sv ***
`timescale 1ns/1ps
module icu_far_model (
    input  wire logic        clk,
    input  wire logic        pin_out,
    input  wire logic        pin_oe_n,
    output logic             pin_level,
    output logic [15:0]      first_timer_count,
    output logic [15:0]      third_timer_count
);
    logic drv_q;

    // Timer values change only on clock edges, as a synchronous counter would.
    task automatic load(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        first_timer_count <= a;
        third_timer_count <= b;
    endtask

    task automatic drive(input logic v);
        @(posedge clk);
        drv_q <= v;
    endtask

    initial begin
        drv_q = 1'b0;
        first_timer_count = 16'h0000;
        third_timer_count = 16'h0000;
    end

    // Once the device drives the pin, the wire carries its own level.
    assign pin_level = pin_oe_n ? drv_q : pin_out;
endmodule // icu_far_model

// *** input_capture_unit_test.sv ***
`timescale 1ns/1ps
module input_capture_unit_test;
    logic                  clk;
    logic                  rst;
    icu_pkg::icu_bus_req_t req;
    logic [7:0]            rdata;
    logic                  pin_level;
    logic                  pin_out;
    logic                  pin_oe_n;
    logic [15:0]           t1;
    logic [15:0]           t3;
    logic                  irq;
    logic                  cap_pulse;
    int                    n_mismatch;
    int                    cmp_count;
    int                    n_pulse;
    logic [3:0]            modes [4];
    int                    counts [4];

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (cap_pulse === 1'b1) begin
            n_pulse++;
        end
    end

    icu_top u_dut (
        .clk(clk), .rst(rst), .bus_req(req), .rdata(rdata), .pin_in(pin_level),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .first_timer_count(t1),
        .third_timer_count(t3), .irq(irq), .capture_pulse(cap_pulse)
    );

    icu_far_model u_far (
        .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level),
        .first_timer_count(t1), .third_timer_count(t3)
    );

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask

    task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    task automatic chk_cap(input logic [15:0] exp);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(icu_pkg::ADDR_CAP_LO, lo);
        rd(icu_pkg::ADDR_CAP_HI, hi);
        chk({hi, lo}, exp);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            u_far.drive(1'b1);
            repeat (6) @(posedge clk);
            u_far.drive(1'b0);
            repeat (6) @(posedge clk);
        end
    endtask

    task automatic set_mode(input logic [3:0] m);
        wr(icu_pkg::ADDR_CTRL, {4'h0, m});
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        n_mismatch = 0;
        cmp_count = 0;
        n_pulse = 0;
        modes = '{icu_pkg::MODE_FALL, icu_pkg::MODE_RISE, icu_pkg::MODE_RISE4,
                  icu_pkg::MODE_RISE16};
        counts = '{1, 1, 4, 16};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_rd(icu_pkg::ADDR_CTRL, icu_pkg::CTRL_RST);
        chk_rd(icu_pkg::ADDR_DIR, icu_pkg::DIR_RST);
        chk_rd(icu_pkg::ADDR_T3CTRL, icu_pkg::T3CTRL_RST);
        chk({15'h0000, pin_oe_n}, 16'h0001);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            u_far.load(16'h1230 | 16'(i), 16'hA5C0 | 16'(i));
            wr(icu_pkg::ADDR_T3CTRL, {7'h00, i[0]});
            set_mode(icu_pkg::MODE_OFF);
            set_mode(modes[i]);
            wr(icu_pkg::ADDR_FLAGS, 8'h00);
            n_pulse = 0;
            pulse(counts[i] - 1);
            chk_rd(icu_pkg::ADDR_FLAGS, 8'h00);
            pulse(1);
            chk_rd(icu_pkg::ADDR_FLAGS, 8'h04);
            chk_cap(i[0] ? (16'hA5C0 | 16'(i)) : (16'h1230 | 16'(i)));
            chk(16'(n_pulse), 16'h0001);
        end
        $display("Test mode table done");
        set_mode(icu_pkg::MODE_RISE);
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        wr(icu_pkg::ADDR_ENABLES, 8'h04);
        u_far.load(16'h0102, 16'h0304);
        pulse(1);
        u_far.load(16'h0506, 16'h0708);
        pulse(1);
        chk_cap(16'h0708);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h04);
        chk({15'h0000, irq}, 16'h0001);
        wr(icu_pkg::ADDR_ENABLES, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        wr(icu_pkg::ADDR_ENABLES, 8'h04);
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        $display("Test overwrite and interrupt done");
        wr(icu_pkg::ADDR_ENABLES, 8'h00);
        set_mode(icu_pkg::MODE_OFF);
        set_mode(icu_pkg::MODE_RISE4);
        pulse(2);
        set_mode(icu_pkg::MODE_OFF);
        set_mode(icu_pkg::MODE_RISE4);
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        pulse(3);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h00);
        pulse(1);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h04);
        pulse(3);
        set_mode(icu_pkg::MODE_RISE16);
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        pulse(12);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h00);
        pulse(1);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h04);
        $display("Test prescaler done");
        set_mode(icu_pkg::MODE_OFF);
        wr(icu_pkg::ADDR_PORT, 8'h00);
        wr(icu_pkg::ADDR_DIR, 8'hFB);
        set_mode(icu_pkg::MODE_RISE);
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        chk({15'h0000, pin_oe_n}, 16'h0000);
        wr(icu_pkg::ADDR_PORT, 8'h04);
        repeat (6) @(posedge clk);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h04);
        // A mode change while capturing with the pin high flags spuriously.
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        set_mode(icu_pkg::MODE_FALL);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h04);
        set_mode(4'h1);
        wr(icu_pkg::ADDR_FLAGS, 8'h00);
        wr(icu_pkg::ADDR_PORT, 8'h00);
        repeat (6) @(posedge clk);
        chk_rd(icu_pkg::ADDR_FLAGS, 8'h00);
        $display("Test output pin capture done");
        close_out();
    end
endmodule // input_capture_unit_test
